// file: dv/front_end_model.sv
// Behavioural sampling front end answering the sequencer's requests.
// Assumes requests are one-cycle pulses on the core clock.
`timescale 1ns/1ps
module front_end_model (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     sampleRequest,
  input  wire logic [4:0]               channelSelect,
  input  wire logic [23:0]              switchAbove,
  input  wire logic                     slow,
  output switch_scan_pkg::sample_t      sampleResult
);
  int         waitLeft;
  logic [4:0] heldChannel;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitLeft = 0;
      heldChannel = 5'h00;
      sampleResult <= '0;
    end else begin
      // Stale result lines keep moving outside a valid answer
      sampleResult <= {1'b0, ~sampleResult.above, ~sampleResult.code};
      if (sampleRequest) begin
        heldChannel = channelSelect;
        waitLeft = slow ? 6 : 1;
      end else if (waitLeft == 1) begin
        sampleResult <= {1'b1, switchAbove[heldChannel], heldChannel, 5'h15};
        waitLeft = 0;
      end else if (waitLeft > 1) begin
        waitLeft = waitLeft - 1;
      end
    end
  end
endmodule

// file: dv/switch_scan_sva.sv
// Port checker for the switch scan sequencer.
// Assumes the core and serial clocks share one async active-low reset.
`timescale 1ns/1ps
module switch_scan_sva #(
  parameter int US_CYCLES = switch_scan_pkg::US_CYCLES
) (
  input wire logic                       clock,
  input wire logic                       rst_n,
  input wire logic                       startScan,
  input wire logic                       clockEnable,
  input wire switch_scan_pkg::scan_cfg_t scanCfg,
  input wire logic [11:0][2:0]           driveLevelCfgA,
  input wire logic [11:0][2:0]           driveLevelCfgB,
  input wire logic [23:0]                inputModeAdc,
  input wire logic [23:0]                channelEnable,
  input wire logic                       sampleRequest,
  input wire logic                       sampleUseAdc,
  input wire logic [4:0]                 channelSelect,
  input wire logic [23:0]                wettingEnable,
  input wire logic [23:0][2:0]           wettingLevel,
  input wire logic                       switchChangeFlag,
  input wire logic                       int_n,
  input wire logic                       spiClock,
  input wire logic                       spiChangeFlag
);
  logic [23:0][2:0] cfgLevel;
  logic [23:0]      lastWet;
  logic [15:0]      onCount;
  logic             stdPoll;
  assign cfgLevel = {driveLevelCfgB, driveLevelCfgA};
  assign stdPoll  = scanCfg.pollMode && scanCfg.gridSize == switch_scan_pkg::GRID_NONE;
  // Cycles since the drive pattern last changed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lastWet <= '0;
      onCount <= '0;
    end else begin
      lastWet <= wettingEnable;
      onCount <= (wettingEnable != lastWet) ? 16'h0000 : onCount + 16'h0001;
    end
  end
  sequence reachesSpi;
    ##[1:3] spiChangeFlag;
  endsequence
  int_mirror_a : assert property (@(posedge clock) disable iff (!rst_n) int_n == !switchChangeFlag)
    else $error("interrupt pin differs from change flag");
  req_pulse_a : assert property (@(posedge clock) disable iff (!rst_n) sampleRequest |=> !sampleRequest)
    else $error("sample request longer than one cycle");
  idle_drive_a : assert property (@(posedge clock) disable iff (!rst_n)
    !startScan && clockEnable |=> wettingEnable == '0 && !sampleRequest)
    else $error("drive or request while scan stopped");
  poll_single_a : assert property (@(posedge clock) disable iff (!rst_n) stdPoll |-> $onehot0(wettingEnable))
    else $error("more than one input driven while polling");
  req_mode_a : assert property (@(posedge clock) disable iff (!rst_n)
    sampleRequest && scanCfg.gridSize == switch_scan_pkg::GRID_NONE |->
    (channelSelect == 5'h00 || channelEnable[channelSelect]) && sampleUseAdc == inputModeAdc[channelSelect])
    else $error("wrong channel or sampling mode");
  cont_level_a : assert property (@(posedge clock) disable iff (!rst_n)
    sampleRequest && !scanCfg.pollMode |-> wettingLevel[channelSelect] == cfgLevel[channelSelect])
    else $error("drive level differs from configuration");
  cont_wet_a : assert property (@(posedge clock) disable iff (!rst_n)
    sampleRequest && !scanCfg.pollMode |-> wettingEnable[channelSelect] || cfgLevel[channelSelect] == 3'h0)
    else $error("sampled input not driven in continuous mode");
  on_time_a : assert property (@(posedge clock) disable iff (!rst_n)
    sampleRequest && stdPoll |-> onCount >= (32'd64 << scanCfg.scanOnTimeField) * US_CYCLES - US_CYCLES
    && onCount <= (32'd64 << scanCfg.scanOnTimeField) * US_CYCLES + 3 * US_CYCLES)
    else $error("on-time before sampling out of range");
  spi_flag_a : assert property (@(posedge spiClock) disable iff (!rst_n) $rose(switchChangeFlag) |-> reachesSpi)
    else $error("change flag not seen on serial side");
endmodule
bind switch_scan_sequencer switch_scan_sva #(.US_CYCLES(US_CYCLES)) switch_scan_sva_inst (
  .clock, .rst_n, .startScan, .clockEnable, .scanCfg, .driveLevelCfgA, .driveLevelCfgB, .inputModeAdc,
  .channelEnable, .sampleRequest, .sampleUseAdc, .channelSelect, .wettingEnable, .wettingLevel,
  .switchChangeFlag, .int_n, .spiClock, .spiChangeFlag
);

// file: dv/tb_top.sv
// Self-checking bench for the switch scan sequencer.
// Assumes the front end model and the bound port checker.
`timescale 1ns/1ps
module tb_top;
  logic                       clock, rst_n, clockEnable, startScan, slow, spiClock, spiStatusRead;
  logic                       sampleRequest, sampleUseAdc, switchChangeFlag, int_n, scanBusy, spiChangeFlag;
  switch_scan_pkg::scan_cfg_t scanCfg;
  switch_scan_pkg::sample_t   sampleResult;
  logic [11:0][2:0]           driveLevelCfgA, driveLevelCfgB;
  logic [23:0][2:0]           wettingLevel;
  logic [23:0]                inputModeAdc, channelEnable, channelIntEnable, switchAbove, mask;
  logic [23:0]                wettingEnable, currentSourceRole, compStateReg;
  logic [11:0]                adcStateRegA, adcStateRegB;
  logic [11:0][9:0]           adcValueReg;
  logic [4:0]                 channelSelect;
  int                         err_count, total_checks, seed;
  int                         order[$];
  switch_scan_sequencer #(.TURN_ON_DELAY_US(20), .US_CYCLES(10)) switch_scan_sequencer_inst (
    .clock, .rst_n, .clockEnable, .startScan, .scanCfg, .driveLevelCfgA, .driveLevelCfgB, .inputModeAdc,
    .channelEnable, .channelIntEnable, .sampleResult, .sampleRequest, .sampleUseAdc, .channelSelect,
    .wettingEnable, .wettingLevel, .currentSourceRole, .compStateReg, .adcStateRegA, .adcStateRegB,
    .adcValueReg, .switchChangeFlag, .int_n, .scanBusy, .spiClock, .spiStatusRead, .spiChangeFlag
  );
  front_end_model front_end_model_inst (
    .clock, .rst_n, .sampleRequest, .channelSelect, .switchAbove, .slow, .sampleResult
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    spiClock = 1'b0;
    #37;
    forever #80 spiClock = ~spiClock;
  end
  always @(negedge clock) begin
    if (sampleRequest === 1'b1)
      order.push_back(channelSelect);
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task waitFlag(input int limit);
    int n;
    n = 0;
    while (switchChangeFlag !== 1'b1 && n < limit) begin
      @(negedge clock);
      n++;
    end
    check(switchChangeFlag, 1);
    check(int_n, 0);
  endtask
  task spiRead;
    @(negedge spiClock);
    spiStatusRead = 1'b1;
    @(negedge spiClock);
    spiStatusRead = 1'b0;
    repeat (10) @(negedge clock);
    check(switchChangeFlag, 0);
    check(int_n, 1);
  endtask
  task checkStates;
    int k;
    k = 0;
    for (int i = 0; i < 24; i++) begin
      if (channelEnable[i]) begin
        check(k < order.size() ? order[k] : 99, i);
        k++;
        if (!inputModeAdc[i])
          check(compStateReg[i], switchAbove[i]);
        else if (i < 12)
          check({adcStateRegA[i], adcValueReg[i]}, {switchAbove[i], 10'(i * 32 + 21)});
        else
          check(adcStateRegB[i - 12], switchAbove[i]);
      end
    end
    order.delete();
  endtask
  initial begin
    #800us;
    err_count++;
    results();
  end
  initial begin
    seed = 32'h32021cb1;
    {rst_n, clockEnable, startScan, slow, spiStatusRead} = '0;
    scanCfg = '0;
    for (int i = 0; i < 12; i++) begin
      driveLevelCfgA[i] = 3'($unsigned($random(seed)) % 5 + 1);
      driveLevelCfgB[i] = 3'($unsigned($random(seed)) % 5 + 1);
    end
    driveLevelCfgA[3] = 3'h0;
    channelEnable = 24'($random(seed)) | 24'h000009;
    mask = channelEnable & 24'hfffff7;
    inputModeAdc = 24'($random(seed)) & 24'hfffffe;
    channelIntEnable = 24'hffffff;
    switchAbove = 24'($random(seed));
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock) clockEnable = 1'($random(seed));
    check(scanBusy, 0);
    clockEnable = 1'b1;
    for (int g = 1; g < 4; g++) begin
      scanCfg.gridSize = switch_scan_pkg::grid_size_t'(g);
      scanCfg.sharedPinSource = 2'($random(seed));
      #1;
      for (int i = 4; i < 16; i++)
        check(currentSourceRole[i], i >= 10 ? 1 : (i == 8 && g == 1) ? scanCfg.sharedPinSource[0]
          : (i == 9 && g < 3) ? scanCfg.sharedPinSource[1] : 0);
    end
    scanCfg.gridSize = switch_scan_pkg::GRID_NONE;
    @(negedge clock);
    startScan = 1'b1;
    repeat (150) @(negedge clock);
    check(wettingEnable, 0);
    repeat (110) @(negedge clock);
    check(wettingEnable & mask, mask);
    waitFlag(20000);
    checkStates();
    repeat (2) begin
      switchAbove[1] = ~switchAbove[1];
      repeat (20) @(negedge clock);
    end
    repeat (40) @(negedge clock);
    check(spiChangeFlag, 1);
    spiRead();
    switchAbove[0] = ~switchAbove[0];
    slow = 1'b1;
    waitFlag(30000);
    checkStates();
    spiRead();
    startScan = 1'b0;
    repeat (2) @(negedge clock);
    check({wettingEnable, scanBusy}, 0);
    scanCfg.pollMode = 1'b1;
    channelEnable = 24'h000005;
    order.delete();
    @(negedge clock);
    startScan = 1'b1;
    waitFlag(40000);
    checkStates();
    spiRead();
    repeat (24000) @(negedge clock);
    check(switchChangeFlag, 0);
    check(order.size() >= 2, 1);
    startScan = 1'b0;
    repeat (4) @(negedge clock);
    results();
  end
endmodule

// file: src/switch_scan_pkg.sv
// Constants, codes and carrier types for the switch scan sequencer.
// Assumes a 100 MHz core clock; timing is counted in microsecond and millisecond ticks.
// Function
// [RULE_01] Continuous mode: all enabled inputs driven, scanned in order
// [RULE_02] Six drive levels per input from two configs
// [RULE_03] Per-input choice of comparator or ADC
// [RULE_04] Start bit waits turn-on delay before driving
// [RULE_05] Store threshold result as baseline per input
// [RULE_06] ADC inputs also store converted value; the code stores the value only for inputs 0 to 11
// [RULE_07] First cycle end: interrupt low, change flag set
// [RULE_08] Status read clears flag and releases interrupt
// [RULE_09] Later cycles interrupt only on detected change
// [RULE_10] Scan period sets sampling repetition rate
// [RULE_11] Zero-level inputs undriven but still sampled
// [RULE_12] Polling drives one channel at a time, ordered
// [RULE_13] Polling change interrupts only if channel enabled
// [RULE_14] Start bit begins polling; standard or matrix
// [RULE_15] Standard on-time 64 to 2048 us, sample at end
// [RULE_16] Polled scan period 2 to 4096 ms
// [RULE_17] Changes between sampling windows are never seen
// [RULE_18] Inputs four to fifteen form matrix group
// [RULE_19] Matrix size zero: all inputs standard on-time
// [RULE_20] Nonzero size: members use matrix on-time
// [RULE_21] Sink and source roles per matrix size
// [RULE_22] Non-members keep the standard on-time
// [RULE_23] Compare with baseline, flag mismatch, update baseline
package switch_scan_pkg;
  localparam int CHANNELS          = 24;
  localparam int ADC_SLOTS         = 12;
  localparam int ADC_BITS          = 10;
  localparam int CLOCK_MHZ         = 100;
  localparam int US_CYCLES         = CLOCK_MHZ;
  localparam int MS_PER_US         = 1000;
  localparam int TURN_ON_DELAY_US  = 200;
  localparam int ON_TIME_BASE_LOG2 = 6;
  localparam int PERIOD_BASE_LOG2  = 1;
  localparam logic [2:0] ON_TIME_CODE_MAX = 3'h5;
  localparam logic [3:0] PERIOD_CODE_MAX  = 4'hb;
  localparam logic [4:0] CHANNEL_FIRST    = 5'h00;
  localparam logic [4:0] CHANNEL_LAST     = 5'h17;
  localparam logic [4:0] GRID_FIRST       = 5'h04;
  localparam logic [4:0] GRID_SOURCE_LO   = 5'h0a;
  localparam logic [4:0] GRID_LAST        = 5'h0f;
  localparam logic [4:0] SHARED_PIN_A     = 5'h08;
  localparam logic [4:0] SHARED_PIN_B     = 5'h09;
  localparam logic [4:0] GRID4_LAST_SINK  = 5'h07;
  localparam logic [4:0] GRID4_LAST_SRC   = 5'h0d;
  localparam logic [4:0] GRID5_LAST_SINK  = 5'h08;
  localparam logic [4:0] GRID5_LAST_SRC   = 5'h0e;

  typedef enum logic [1:0] {
    GRID_NONE = 2'h0,
    GRID_4X4  = 2'h1,
    GRID_5X5  = 2'h2,
    GRID_6X6  = 2'h3
  } grid_size_t;

  // Drive level codes: 0,1,2,5,10,15 mA; codes 6 and 7 mean off
  typedef enum logic [2:0] {
    LEVEL_0MA  = 3'h0,
    LEVEL_1MA  = 3'h1,
    LEVEL_2MA  = 3'h2,
    LEVEL_5MA  = 3'h3,
    LEVEL_10MA = 3'h4,
    LEVEL_15MA = 3'h5
  } drive_level_t;

  typedef struct packed {
    logic                pollMode;
    grid_size_t          gridSize;
    logic [2:0]          scanOnTimeField;
    logic [2:0]          gridOnTimeField;
    logic [3:0]          scanPeriodField;
    logic [1:0]          sharedPinSource;
  } scan_cfg_t;

  typedef struct packed {
    logic                done;
    logic                above;
    logic [ADC_BITS-1:0] code;
  } sample_t;
endpackage

// file: src/switch_scan_sequencer.sv
// Scan sequencer for a 24-input switch detection front end.
// Assumes the front end answers each sample request on the core clock and
// that the serial host side clocks a read pulse on its own clock.
`timescale 1ns/1ps
module switch_scan_sequencer #(
  parameter int TURN_ON_DELAY_US = switch_scan_pkg::TURN_ON_DELAY_US,
  parameter int US_CYCLES        = switch_scan_pkg::US_CYCLES
) (
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  input  wire logic                                clockEnable,
  input  wire logic                                startScan,
  input  wire switch_scan_pkg::scan_cfg_t          scanCfg,
  input  wire logic [11:0][2:0]                    driveLevelCfgA,
  input  wire logic [11:0][2:0]                    driveLevelCfgB,
  input  wire logic [23:0]                         inputModeAdc,
  input  wire logic [23:0]                         channelEnable,
  input  wire logic [23:0]                         channelIntEnable,
  input  wire switch_scan_pkg::sample_t            sampleResult,
  output logic                                     sampleRequest,
  output logic                                     sampleUseAdc,
  output logic [4:0]                               channelSelect,
  output logic [23:0]                              wettingEnable,
  output logic [23:0][2:0]                         wettingLevel,
  output logic [23:0]                              currentSourceRole,
  output logic [23:0]                              compStateReg,
  output logic [11:0]                              adcStateRegA,
  output logic [11:0]                              adcStateRegB,
  output logic [11:0][9:0]                         adcValueReg,
  output logic                                     switchChangeFlag,
  output logic                                     int_n,
  output logic                                     scanBusy,
  input  wire logic                                spiClock,
  input  wire logic                                spiStatusRead,
  output logic                                     spiChangeFlag
);
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_STARTUP = 3'b001,
    S_ONTIME  = 3'b011,
    S_SAMPLE  = 3'b010,
    S_ADVANCE = 3'b110,
    S_WAIT    = 3'b111
  } scan_state_t;

  function automatic logic isGridMember(input logic [4:0] ch, input switch_scan_pkg::grid_size_t sz);
    logic member;
    member = 1'b0;
    case (sz)
      switch_scan_pkg::GRID_4X4: member = (ch >= switch_scan_pkg::GRID_FIRST && ch <= switch_scan_pkg::GRID4_LAST_SINK)
                                       || (ch >= switch_scan_pkg::GRID_SOURCE_LO && ch <= switch_scan_pkg::GRID4_LAST_SRC);
      switch_scan_pkg::GRID_5X5: member = (ch >= switch_scan_pkg::GRID_FIRST && ch <= switch_scan_pkg::GRID5_LAST_SINK)
                                       || (ch >= switch_scan_pkg::GRID_SOURCE_LO && ch <= switch_scan_pkg::GRID5_LAST_SRC);
      switch_scan_pkg::GRID_6X6: member = (ch >= switch_scan_pkg::GRID_FIRST && ch <= switch_scan_pkg::GRID_LAST);
      default:                   member = 1'b0;
    endcase
    return member; // [RULE_18] [RULE_22]
  endfunction

  function automatic logic [2:0] levelOf(input logic [4:0] ch);
    logic [2:0] lv;
    lv = (ch < 5'(switch_scan_pkg::ADC_SLOTS)) ? driveLevelCfgA[ch[3:0]]
                                                : driveLevelCfgB[4'(ch - 5'(switch_scan_pkg::ADC_SLOTS))];
    return lv; // [RULE_02]
  endfunction

  localparam int STARTUP_US = TURN_ON_DELAY_US;

  scan_state_t state;
  logic [4:0]  channel;
  logic [6:0]  usPrescale;
  logic        usTick;
  logic [9:0]  msPrescale;
  logic        msTick;
  logic [11:0] usCount;
  logic [12:0] msCount;
  logic        firstCycle;
  logic        changeSeen;
  logic        cycleDone;
  logic [11:0] onTimeUs;
  logic [12:0] periodMs;
  logic        readToggleSpi;
  logic        readSync1;
  logic        readSync2;
  logic        readSync3;
  logic        readPulse;
  logic        flagSync1;
  logic        flagSync2;
  logic        lastEnabled;
  logic [4:0]  nextChannel;
  logic        advanceReq;
  logic        restartReq;
  logic [4:0]  reqChannel;

  // Microsecond and millisecond time base, frozen with the clock enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      usPrescale <= '0;
      msPrescale <= '0;
    end else if (clockEnable) begin
      usPrescale <= usTick ? '0 : usPrescale + 7'h01;
      if (usTick) begin
        msPrescale <= msTick ? '0 : msPrescale + 10'h001;
      end
    end
  end
  assign usTick = (usPrescale == 7'(US_CYCLES - 1));
  assign msTick = usTick && (msPrescale == 10'(switch_scan_pkg::MS_PER_US - 1));

  // On-time per channel: matrix members use their own field
  always_comb begin
    if (scanCfg.gridSize != switch_scan_pkg::GRID_NONE && isGridMember(channel, scanCfg.gridSize)) begin
      onTimeUs = 12'h001 << ({1'b0, scanCfg.gridOnTimeField} + 4'(switch_scan_pkg::ON_TIME_BASE_LOG2)); // [RULE_20]
    end else begin
      onTimeUs = 12'h001 << ({1'b0, scanCfg.scanOnTimeField} + 4'(switch_scan_pkg::ON_TIME_BASE_LOG2)); // [RULE_15]
    end
    periodMs = 13'h0001 << (scanCfg.scanPeriodField + 4'(switch_scan_pkg::PERIOD_BASE_LOG2)); // [RULE_10] [RULE_16]
  end

  // Next enabled channel in ascending order; in polling mode matrix members cannot be disabled
  always_comb begin
    nextChannel = channel;
    lastEnabled = 1'b1;
    for (int i = switch_scan_pkg::CHANNELS - 1; i >= 0; i--) begin
      if (5'(i) > channel && (channelEnable[i] || (scanCfg.pollMode && isGridMember(5'(i), scanCfg.gridSize)))) begin
        nextChannel = 5'(i);
        lastEnabled = 1'b0;
      end
    end
  end

  assign cycleDone = (state == S_ADVANCE) && lastEnabled;

  // Continuous requests name the channel the sequence moves to, not the old one
  assign advanceReq = (state == S_ADVANCE) && !lastEnabled && !scanCfg.pollMode;
  assign restartReq = (state == S_WAIT) && (msCount >= periodMs) && !scanCfg.pollMode;
  assign reqChannel = advanceReq ? nextChannel : restartReq ? switch_scan_pkg::CHANNEL_FIRST : channel;

  // Scan sequence
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state   <= S_IDLE;
      channel <= switch_scan_pkg::CHANNEL_FIRST;
      usCount <= '0;
    end else if (clockEnable) begin
      if (!startScan) begin
        state   <= S_IDLE;
        channel <= switch_scan_pkg::CHANNEL_FIRST;
        usCount <= '0;
      end else begin
        case (state)
          S_IDLE: begin
            usCount <= '0;
            channel <= switch_scan_pkg::CHANNEL_FIRST;
            state   <= scanCfg.pollMode ? S_ONTIME : S_STARTUP; // [RULE_14]
          end
          S_STARTUP: begin
            if (usTick) begin
              usCount <= usCount + 12'h001;
            end
            if (usCount >= 12'(STARTUP_US)) begin // [RULE_04]
              usCount <= '0;
              state   <= S_SAMPLE;
            end
          end
          S_ONTIME: begin
            if (usTick) begin
              usCount <= usCount + 12'h001;
            end
            if (usCount >= onTimeUs) begin // [RULE_15]
              usCount <= '0;
              state   <= S_SAMPLE;
            end
          end
          S_SAMPLE: begin
            if (sampleResult.done) begin
              state <= S_ADVANCE;
            end
          end
          S_ADVANCE: begin
            if (lastEnabled) begin
              state <= S_WAIT;
            end else begin
              channel <= nextChannel; // [RULE_01] [RULE_12]
              state   <= scanCfg.pollMode ? S_ONTIME : S_SAMPLE;
            end
          end
          S_WAIT: begin
            if (msCount >= periodMs) begin
              channel <= switch_scan_pkg::CHANNEL_FIRST;
              state   <= scanCfg.pollMode ? S_ONTIME : S_SAMPLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Period counter runs from the start of each scan cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msCount <= '0;
    end else if (clockEnable) begin
      if (state == S_IDLE || (state == S_WAIT && msCount >= periodMs)) begin
        msCount <= '0;
      end else if (msTick && msCount != 13'h1fff) begin
        msCount <= msCount + 13'h0001; // [RULE_10] [RULE_16]
      end
    end
  end

  // Drive and sample strobes to the front end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wettingEnable <= '0;
      wettingLevel  <= '0;
      sampleRequest <= 1'b0;
      sampleUseAdc  <= 1'b0;
      channelSelect <= '0;
    end else if (clockEnable) begin
      sampleRequest <= 1'b0;
      channelSelect <= reqChannel;
      sampleUseAdc  <= inputModeAdc[reqChannel]; // [RULE_03]
      for (int i = 0; i < switch_scan_pkg::CHANNELS; i++) begin
        wettingLevel[i] <= levelOf(5'(i)); // [RULE_02]
        if (!startScan || state == S_IDLE || (state == S_STARTUP && usCount < 12'(STARTUP_US))
            || levelOf(5'(i)) == switch_scan_pkg::LEVEL_0MA
            || levelOf(5'(i)) > switch_scan_pkg::LEVEL_15MA) begin
          wettingEnable[i] <= 1'b0; // [RULE_11] [RULE_04]
        end else if (scanCfg.pollMode) begin
          wettingEnable[i] <= (state == S_ONTIME) && (5'(i) == channel); // [RULE_12]
        end else begin
          wettingEnable[i] <= channelEnable[i]; // [RULE_01]
        end
      end
      if (startScan && ((state == S_STARTUP && usCount >= 12'(STARTUP_US))
          || (state == S_ONTIME && usCount >= onTimeUs)
          || advanceReq || restartReq)) begin
        sampleRequest <= 1'b1; // [RULE_15] [RULE_17]
      end
    end
  end

  // Sink or source role for each input under the chosen matrix size
  always_comb begin
    for (int i = 0; i < switch_scan_pkg::CHANNELS; i++) begin
      currentSourceRole[i] = 1'b1;
      if (isGridMember(5'(i), switch_scan_pkg::GRID_6X6) && scanCfg.gridSize != switch_scan_pkg::GRID_NONE) begin
        currentSourceRole[i] = (5'(i) >= switch_scan_pkg::GRID_SOURCE_LO); // [RULE_21]
        if (5'(i) == switch_scan_pkg::SHARED_PIN_A && scanCfg.gridSize == switch_scan_pkg::GRID_4X4) begin
          currentSourceRole[i] = scanCfg.sharedPinSource[0];
        end
        if (5'(i) == switch_scan_pkg::SHARED_PIN_B && scanCfg.gridSize != switch_scan_pkg::GRID_6X6) begin
          currentSourceRole[i] = scanCfg.sharedPinSource[1];
        end
      end
    end
  end

  // Baseline store, change detection and result capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compStateReg <= '0;
      adcStateRegA <= '0;
      adcStateRegB <= '0;
      adcValueReg  <= '0;
      changeSeen   <= 1'b0;
      firstCycle   <= 1'b1;
    end else if (clockEnable) begin
      if (state == S_IDLE) begin
        changeSeen <= 1'b0;
        firstCycle <= 1'b1;
      end else if (cycleDone) begin
        changeSeen <= 1'b0;
        firstCycle <= 1'b0;
      end else if (state == S_SAMPLE && sampleResult.done) begin
        if (inputModeAdc[channel]) begin // [RULE_05]
          if (channel < 5'(switch_scan_pkg::ADC_SLOTS)) begin
            adcStateRegA[channel[3:0]] <= sampleResult.above;
            adcValueReg[channel[3:0]]  <= sampleResult.code; // [RULE_06]
          end else begin
            adcStateRegB[4'(channel - 5'(switch_scan_pkg::ADC_SLOTS))] <= sampleResult.above;
          end
        end else begin
          compStateReg[channel] <= sampleResult.above; // [RULE_05] [RULE_23]
        end
        if (!firstCycle && channelIntEnable[channel] && sampleResult.above != (inputModeAdc[channel]
            ? (channel < 5'(switch_scan_pkg::ADC_SLOTS) ? adcStateRegA[channel[3:0]]
               : adcStateRegB[4'(channel - 5'(switch_scan_pkg::ADC_SLOTS))])
            : compStateReg[channel])) begin
          changeSeen <= 1'b1; // [RULE_23] [RULE_13]
        end
      end
    end
  end

  // Status-change flag: a cycle end that flags (first cycle or change seen) wins over a simultaneous read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      switchChangeFlag <= 1'b0;
    end else if (clockEnable) begin
      if (cycleDone && (firstCycle || changeSeen)) begin
        switchChangeFlag <= 1'b1; // [RULE_07] [RULE_09] [RULE_13]
      end else if (readPulse) begin
        switchChangeFlag <= 1'b0; // [RULE_08]
      end
    end
  end

  assign int_n    = ~switchChangeFlag; // [RULE_07] [RULE_08]
  assign scanBusy = (state != S_IDLE);

  // Serial side: read event as a toggle, flag status as a synchronised level
  always_ff @(posedge spiClock or negedge rst_n) begin
    if (!rst_n) begin
      readToggleSpi <= 1'b0;
      flagSync1     <= 1'b0;
      flagSync2     <= 1'b0;
    end else begin
      flagSync1 <= switchChangeFlag;
      flagSync2 <= flagSync1;
      if (spiStatusRead) begin
        readToggleSpi <= ~readToggleSpi;
      end
    end
  end
  assign spiChangeFlag = flagSync2; // [RULE_07]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readSync1 <= 1'b0;
      readSync2 <= 1'b0;
      readSync3 <= 1'b0;
    end else if (clockEnable) begin
      readSync1 <= readToggleSpi;
      readSync2 <= readSync1;
      readSync3 <= readSync2;
    end
  end
  assign readPulse = readSync2 ^ readSync3; // [RULE_08]
endmodule
